/* hdl/caid_regs.vh */
// Constants of the accumulator and index datapath: opcodes, vectors, flag bits, resets
`ifndef CAID_REGS_VH
`define CAID_REGS_VH

// Page-select prebyte: following opcode works on the secondary index
`define CAID_OP_PREBYTE   8'h18

// Inherent opcodes
`define CAID_OP_NOP       8'h01
`define CAID_OP_IDIV      8'h02
`define CAID_OP_FDIV      8'h03
`define CAID_OP_TAP       8'h06
`define CAID_OP_TPA       8'h07
`define CAID_OP_INX       8'h08
`define CAID_OP_DEX       8'h09
`define CAID_OP_SBA       8'h10
`define CAID_OP_CBA       8'h11
`define CAID_OP_DAA       8'h19
`define CAID_OP_ABA       8'h1b
`define CAID_OP_PULA      8'h32
`define CAID_OP_PSHA      8'h36
`define CAID_OP_ABX       8'h3a
`define CAID_OP_SWAP_DOUBLE_WITH_PRIMARY_INDEX      8'h8f

// Immediate, full address and indexed opcodes
`define CAID_OP_LDAA_IMM  8'h86
`define CAID_OP_LDAB_IMM  8'hc6
`define CAID_OP_LDX_IMM   8'hce
`define CAID_OP_LDS_IMM   8'h8e
`define CAID_OP_LDAA_EXT  8'hb6
`define CAID_OP_LDAA_IDX  8'ha6
`define CAID_OP_STAA_IDX  8'ha7
`define CAID_OP_BSET_IDX  8'h1c
`define CAID_OP_BCLR_IDX  8'h1d

// Vector addresses (high byte at the address, low byte at the next)
`define CAID_VEC_RESET    16'hfffe
`define CAID_VEC_XIRQ     16'hfff4
`define CAID_VEC_IRQ      16'hfff2

// Condition flag bit positions
`define CAID_CF_S         7
`define CAID_CF_X         6
`define CAID_CF_H         5
`define CAID_CF_I         4
`define CAID_CF_N         3
`define CAID_CF_Z         2
`define CAID_CF_V         1
`define CAID_CF_C         0

// Reset values
`define CAID_CF_RESET     8'hd0
`define CAID_SP_RESET     16'h0000

// Counts
`define CAID_DIV_STEPS    5'h10
`define CAID_STACK_BYTES  4'h9

`endif

/* hdl/caid_div.v */
// Iterative 16 by 16 restoring divider for integer and fractional divide
`timescale 1ns/1ns
`include "caid_regs.vh"

module caid_div #(
  parameter WIDTH = 16
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             start,
  input  wire             frac,
  input  wire [WIDTH-1:0] dividend,
  input  wire [WIDTH-1:0] divisor,
  output reg  [WIDTH-1:0] quotient,
  output reg  [WIDTH-1:0] remainder,
  output reg              done,
  output reg              div_zero,
  output reg              overflow
);

  reg  [4:0]   count;
  reg          busy;
  wire [WIDTH:0] trial = {remainder, quotient[WIDTH-1]};
  wire         fits  = trial >= {1'b0, divisor};
  wire [WIDTH:0] diff = trial - {1'b0, divisor};

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      quotient  <= {WIDTH{1'b0}};
      remainder <= {WIDTH{1'b0}};
      done      <= 1'b0;
      div_zero  <= 1'b0;
      overflow  <= 1'b0;
      count     <= 5'h00;
      busy      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        div_zero <= (divisor == {WIDTH{1'b0}});
        overflow <= frac && (divisor <= dividend);
        if (divisor == {WIDTH{1'b0}} || (frac && divisor <= dividend)) begin
          // Undefined quotient: all ones, dividend left as remainder
          quotient  <= {WIDTH{1'b1}};
          remainder <= dividend;
          done      <= 1'b1;
        end else begin
          // Fractional form divides dividend shifted up by one word
          remainder <= frac ? dividend : {WIDTH{1'b0}};
          quotient  <= frac ? {WIDTH{1'b0}} : dividend;
          count     <= `CAID_DIV_STEPS;
          busy      <= 1'b1;
        end
      end else if (busy) begin
        remainder <= fits ? diff[WIDTH-1:0] : trial[WIDTH-1:0];
        quotient  <= {quotient[WIDTH-2:0], fits};
        count     <= count - 5'h01;
        if (count == 5'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

/* hdl/caid_core.v */
// CPU core: accumulators, index registers, stack, flags and indexed addressing
`timescale 1ns/1ns
`include "caid_regs.vh"

module caid_core (
  input  wire        clock,
  input  wire        rst,
  input  wire [7:0]  bus_rdata,
  input  wire        irq_req,
  input  wire        xirq_req,
  output reg  [15:0] bus_addr,
  output reg  [7:0]  bus_wdata,
  output reg         bus_rd,
  output reg         bus_wr,
  output reg         op_fetch,
  output reg  [7:0]  acc_first,
  output reg  [7:0]  acc_second,
  output reg  [15:0] idx_primary,
  output reg  [15:0] idx_secondary,
  output reg  [15:0] stack_pointer,
  output reg  [15:0] program_counter,
  output reg  [7:0]  condition_flags_register
);

  ////////////////////////////////////////////////////////////////////////////////
  // States

  localparam [11:0] ST_VECH  = 12'h001;
  localparam [11:0] ST_VECL  = 12'h002;
  localparam [11:0] ST_OP    = 12'h004;
  localparam [11:0] ST_OP2   = 12'h008;
  localparam [11:0] ST_IMM1  = 12'h010;
  localparam [11:0] ST_IMM2  = 12'h020;
  localparam [11:0] ST_MASK  = 12'h040;
  localparam [11:0] ST_MEMRD = 12'h080;
  localparam [11:0] ST_WRDN  = 12'h100;
  localparam [11:0] ST_DIV   = 12'h200;
  localparam [11:0] ST_PULL  = 12'h400;
  localparam [11:0] ST_PUSH  = 12'h800;

  reg  [11:0] state;
  reg  [7:0]  op;
  reg         ypage;
  reg  [15:0] ea;
  reg  [7:0]  hold;
  reg  [3:0]  push_cnt;
  reg  [15:0] vec_addr;
  reg         div_start;
  reg         div_frac;

  ////////////////////////////////////////////////////////////////////////////////
  // Arithmetic

  wire [15:0] dbl      = {acc_first, acc_second};
  wire [15:0] idx_sel  = ypage ? idx_secondary : idx_primary;
  // Stream address once this edge's own counter step has landed
  wire [15:0] next_pc  = ((state & (ST_OP | ST_OP2 | ST_IMM1 | ST_IMM2)) != 12'h000) ?
                         program_counter + 16'h0001 : program_counter;
  wire [8:0]  pair_sum = {1'b0, acc_first} + {1'b0, acc_second};
  wire [8:0]  pair_dif = {1'b0, acc_first} - {1'b0, acc_second};
  wire [4:0]  nib_sum  = {1'b0, acc_first[3:0]} + {1'b0, acc_second[3:0]};
  wire        add_ovf  = (acc_first[7] == acc_second[7]) && (pair_sum[7] != acc_first[7]);
  wire        sub_ovf  = (acc_first[7] != acc_second[7]) && (pair_dif[7] != acc_first[7]);
  wire        lo_fix   = condition_flags_register[`CAID_CF_H] || (acc_first[3:0] > 4'h9);
  wire        hi_fix   = condition_flags_register[`CAID_CF_C] || (acc_first[7:4] > 4'h9) ||
                         ((acc_first[7:4] >= 4'h9) && (acc_first[3:0] > 4'h9));
  wire [8:0]  bcd_res  = {1'b0, acc_first} + {2'b00, hi_fix, hi_fix, 2'b00, lo_fix, lo_fix, 1'b0};
  wire        take_x   = xirq_req && !condition_flags_register[`CAID_CF_X];
  wire        take_i   = irq_req && !condition_flags_register[`CAID_CF_I];

  wire [15:0] div_quo;
  wire [15:0] div_rem;
  wire        div_done;
  wire        div_zero;
  wire        div_ovf;

  caid_div #(
    .WIDTH (16)
  ) u_div (
    .clock     (clock),
    .rst       (rst),
    .start     (div_start),
    .frac      (div_frac),
    .dividend  (dbl),
    .divisor   (idx_primary),
    .quotient  (div_quo),
    .remainder (div_rem),
    .done      (div_done),
    .div_zero  (div_zero),
    .overflow  (div_ovf)
  );

  // Byte order stacked on interrupt, first one written at the top
  function [7:0] stack_byte;
    input [3:0] n;
    begin
      case (n)
        4'h0:    stack_byte = next_pc[7:0];
        4'h1:    stack_byte = next_pc[15:8];
        4'h2:    stack_byte = idx_secondary[7:0];
        4'h3:    stack_byte = idx_secondary[15:8];
        4'h4:    stack_byte = idx_primary[7:0];
        4'h5:    stack_byte = idx_primary[15:8];
        4'h6:    stack_byte = acc_first;
        4'h7:    stack_byte = acc_second;
        default: stack_byte = condition_flags_register;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing helpers

  task set_nz8;
    input [7:0] v;
    begin
      condition_flags_register[`CAID_CF_N] <= v[7];
      condition_flags_register[`CAID_CF_Z] <= (v == 8'h00);
      condition_flags_register[`CAID_CF_V] <= 1'b0;
    end
  endtask

  task set_idx;
    input [15:0] v;
    begin
      if (ypage) begin
        idx_secondary <= v;
      end else begin
        idx_primary <= v;
      end
    end
  endtask

  // Instruction boundary: take a pending interrupt or fetch the next opcode
  task end_instr;
    begin
      ypage <= 1'b0;
      if (take_x || take_i) begin
        vec_addr      <= take_x ? `CAID_VEC_XIRQ : `CAID_VEC_IRQ;
        bus_addr      <= stack_pointer;
        bus_wdata     <= stack_byte(4'h0);
        bus_wr        <= 1'b1;
        stack_pointer <= stack_pointer - 16'h0001;
        push_cnt      <= 4'h1;
        state         <= ST_PUSH;
      end else begin
        bus_addr <= next_pc;
        bus_rd   <= 1'b1;
        state    <= ST_OP;
      end
    end
  endtask

  task fetch_next;
    begin
      bus_addr        <= program_counter + 16'h0001;
      bus_rd          <= 1'b1;
      program_counter <= program_counter + 16'h0001;
    end
  endtask

  task decode;
    input [7:0] o;
    begin
      op <= o;
      case (o)
        `CAID_OP_ABA: begin
          acc_first <= pair_sum[7:0];
          condition_flags_register[`CAID_CF_H] <= nib_sum[4];
          condition_flags_register[`CAID_CF_N] <= pair_sum[7];
          condition_flags_register[`CAID_CF_Z] <= (pair_sum[7:0] == 8'h00);
          condition_flags_register[`CAID_CF_V] <= add_ovf;
          condition_flags_register[`CAID_CF_C] <= pair_sum[8];
          end_instr;
        end
        `CAID_OP_SBA, `CAID_OP_CBA: begin
          if (o == `CAID_OP_SBA) begin
            acc_first <= pair_dif[7:0];
          end
          condition_flags_register[`CAID_CF_N] <= pair_dif[7];
          condition_flags_register[`CAID_CF_Z] <= (pair_dif[7:0] == 8'h00);
          condition_flags_register[`CAID_CF_V] <= sub_ovf;
          condition_flags_register[`CAID_CF_C] <= pair_dif[8];
          end_instr;
        end
        `CAID_OP_TAP: begin
          // Software may clear the nonmaskable mask but never set it
          condition_flags_register <= {acc_first[7],
                                       acc_first[6] & condition_flags_register[`CAID_CF_X],
                                       acc_first[5:0]};
          end_instr;
        end
        `CAID_OP_TPA: begin
          acc_first <= condition_flags_register;
          end_instr;
        end
        `CAID_OP_DAA: begin
          acc_first <= bcd_res[7:0];
          condition_flags_register[`CAID_CF_N] <= bcd_res[7];
          condition_flags_register[`CAID_CF_Z] <= (bcd_res[7:0] == 8'h00);
          condition_flags_register[`CAID_CF_C] <= hi_fix | bcd_res[8];
          end_instr;
        end
        `CAID_OP_ABX: begin
          set_idx(idx_sel + {8'h00, acc_second});
          end_instr;
        end
        `CAID_OP_SWAP_DOUBLE_WITH_PRIMARY_INDEX: begin
          set_idx(dbl);
          acc_first  <= idx_sel[15:8];
          acc_second <= idx_sel[7:0];
          end_instr;
        end
        `CAID_OP_INX, `CAID_OP_DEX: begin
          set_idx((o == `CAID_OP_INX) ? idx_sel + 16'h0001 : idx_sel - 16'h0001);
          condition_flags_register[`CAID_CF_Z] <=
            ((o == `CAID_OP_INX) ? idx_sel + 16'h0001 : idx_sel - 16'h0001) == 16'h0000;
          end_instr;
        end
        `CAID_OP_IDIV, `CAID_OP_FDIV: begin
          div_start <= 1'b1;
          div_frac  <= (o == `CAID_OP_FDIV);
          state     <= ST_DIV;
        end
        `CAID_OP_PSHA: begin
          bus_addr      <= stack_pointer;
          bus_wdata     <= acc_first;
          bus_wr        <= 1'b1;
          stack_pointer <= stack_pointer - 16'h0001;
          state         <= ST_WRDN;
        end
        `CAID_OP_PULA: begin
          bus_addr      <= stack_pointer + 16'h0001;
          bus_rd        <= 1'b1;
          stack_pointer <= stack_pointer + 16'h0001;
          state         <= ST_PULL;
        end
        `CAID_OP_LDAA_IMM, `CAID_OP_LDAB_IMM, `CAID_OP_LDX_IMM, `CAID_OP_LDS_IMM,
        `CAID_OP_LDAA_EXT, `CAID_OP_LDAA_IDX, `CAID_OP_STAA_IDX,
        `CAID_OP_BSET_IDX, `CAID_OP_BCLR_IDX: begin
          bus_addr <= next_pc;
          bus_rd   <= 1'b1;
          state    <= ST_IMM1;
        end
        default: begin
          end_instr;
        end
      endcase
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequencer

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_addr                 <= `CAID_VEC_RESET;
      bus_wdata                <= 8'h00;
      bus_rd                   <= 1'b1;
      bus_wr                   <= 1'b0;
      op_fetch                 <= 1'b0;
      acc_first                <= 8'h00;
      acc_second               <= 8'h00;
      idx_primary              <= 16'h0000;
      idx_secondary            <= 16'h0000;
      stack_pointer            <= `CAID_SP_RESET;
      program_counter          <= 16'h0000;
      condition_flags_register <= `CAID_CF_RESET;
      state                    <= ST_VECH;
      op                       <= 8'h00;
      ypage                    <= 1'b0;
      ea                       <= 16'h0000;
      hold                     <= 8'h00;
      push_cnt                 <= 4'h0;
      vec_addr                 <= `CAID_VEC_RESET;
      div_start                <= 1'b0;
      div_frac                 <= 1'b0;
    end else begin
      bus_rd    <= 1'b0;
      bus_wr    <= 1'b0;
      op_fetch  <= 1'b0;
      div_start <= 1'b0;
      case (state)
        ST_VECH: begin
          hold     <= bus_rdata;
          bus_addr <= vec_addr + 16'h0001;
          bus_rd   <= 1'b1;
          state    <= ST_VECL;
        end
        ST_VECL: begin
          program_counter <= {hold, bus_rdata};
          bus_addr        <= {hold, bus_rdata};
          bus_rd          <= 1'b1;
          state           <= ST_OP;
        end
        ST_OP: begin
          op_fetch        <= 1'b1;
          program_counter <= program_counter + 16'h0001;
          if (bus_rdata == `CAID_OP_PREBYTE) begin
            ypage    <= 1'b1;
            bus_addr <= program_counter + 16'h0001;
            bus_rd   <= 1'b1;
            state    <= ST_OP2;
          end else begin
            decode(bus_rdata);
          end
        end
        ST_OP2: begin
          program_counter <= program_counter + 16'h0001;
          decode(bus_rdata);
        end
        ST_IMM1: begin
          program_counter <= program_counter + 16'h0001;
          case (op)
            `CAID_OP_LDAA_IMM: begin
              acc_first <= bus_rdata;
              set_nz8(bus_rdata);
              end_instr;
            end
            `CAID_OP_LDAB_IMM: begin
              acc_second <= bus_rdata;
              set_nz8(bus_rdata);
              end_instr;
            end
            `CAID_OP_LDAA_IDX, `CAID_OP_STAA_IDX, `CAID_OP_BSET_IDX, `CAID_OP_BCLR_IDX: begin
              ea <= idx_sel + {8'h00, bus_rdata};
              if (op == `CAID_OP_STAA_IDX) begin
                bus_addr  <= idx_sel + {8'h00, bus_rdata};
                bus_wdata <= acc_first;
                bus_wr    <= 1'b1;
                set_nz8(acc_first);
                state     <= ST_WRDN;
              end else if (op == `CAID_OP_LDAA_IDX) begin
                bus_addr <= idx_sel + {8'h00, bus_rdata};
                bus_rd   <= 1'b1;
                state    <= ST_MEMRD;
              end else begin
                fetch_next;
                state <= ST_MASK;
              end
            end
            default: begin
              hold  <= bus_rdata;
              fetch_next;
              state <= ST_IMM2;
            end
          endcase
        end
        ST_IMM2: begin
          program_counter <= program_counter + 16'h0001;
          case (op)
            `CAID_OP_LDX_IMM: begin
              set_idx({hold, bus_rdata});
              condition_flags_register[`CAID_CF_N] <= hold[7];
              condition_flags_register[`CAID_CF_Z] <= ({hold, bus_rdata} == 16'h0000);
              condition_flags_register[`CAID_CF_V] <= 1'b0;
              end_instr;
            end
            `CAID_OP_LDS_IMM: begin
              stack_pointer <= {hold, bus_rdata};
              end_instr;
            end
            default: begin
              ea       <= {hold, bus_rdata};
              bus_addr <= {hold, bus_rdata};
              bus_rd   <= 1'b1;
              state    <= ST_MEMRD;
            end
          endcase
        end
        ST_MASK: begin
          program_counter <= program_counter + 16'h0001;
          hold            <= bus_rdata;
          bus_addr        <= ea;
          bus_rd          <= 1'b1;
          state           <= ST_MEMRD;
        end
        ST_MEMRD: begin
          if (op == `CAID_OP_BSET_IDX || op == `CAID_OP_BCLR_IDX) begin
            bus_addr  <= ea;
            bus_wdata <= (op == `CAID_OP_BSET_IDX) ? (bus_rdata | hold) : (bus_rdata & ~hold);
            bus_wr    <= 1'b1;
            set_nz8((op == `CAID_OP_BSET_IDX) ? (bus_rdata | hold) : (bus_rdata & ~hold));
            state     <= ST_WRDN;
          end else begin
            acc_first <= bus_rdata;
            set_nz8(bus_rdata);
            end_instr;
          end
        end
        ST_WRDN: begin
          end_instr;
        end
        ST_DIV: begin
          if (div_done) begin
            idx_primary <= div_quo;
            acc_first   <= div_rem[15:8];
            acc_second  <= div_rem[7:0];
            condition_flags_register[`CAID_CF_Z] <= (div_quo == 16'h0000);
            condition_flags_register[`CAID_CF_V] <= div_frac & div_ovf;
            condition_flags_register[`CAID_CF_C] <= div_zero;
            end_instr;
          end
        end
        ST_PULL: begin
          acc_first <= bus_rdata;
          end_instr;
        end
        ST_PUSH: begin
          if (push_cnt == `CAID_STACK_BYTES) begin
            // Mask further maskable interrupts, then fetch the vector
            condition_flags_register[`CAID_CF_I] <= 1'b1;
            if (vec_addr == `CAID_VEC_XIRQ) begin
              condition_flags_register[`CAID_CF_X] <= 1'b1;
            end
            bus_addr <= vec_addr;
            bus_rd   <= 1'b1;
            state    <= ST_VECH;
          end else begin
            bus_addr      <= stack_pointer;
            bus_wdata     <= stack_byte(push_cnt);
            bus_wr        <= 1'b1;
            stack_pointer <= stack_pointer - 16'h0001;
            push_cnt      <= push_cnt + 4'h1;
          end
        end
        default: begin
          state <= ST_VECH;
        end
      endcase
    end
  end

endmodule

/* verif/caid_mem.sv */
// Memory model on the core's flat byte bus
`timescale 1ns/1ns
module caid_mem (
  input  wire        clock,
  input  wire [15:0] bus_addr,
  input  wire [7:0]  bus_wdata,
  input  wire        bus_rd,
  input  wire        bus_wr,
  output wire [7:0]  bus_rdata
);
  reg     [7:0] mem [0:65535];
  integer       i;
  // Unwritten space holds one-byte no-ops
  initial for (i = 0; i < 65536; i = i + 1) mem[i] = 8'h01;
  // Every address answers alike with no wait; unselected reads show inverted data
  assign bus_rdata = bus_rd ? mem[bus_addr] : ~mem[bus_addr];
  always @(posedge clock) begin
    if (bus_wr) mem[bus_addr] <= bus_wdata;
  end
endmodule

/* verif/caid_core_sva.sv */
// Port checks for the datapath core
`timescale 1ns/1ns
module caid_core_sva (
  input logic        clock,
  input logic        rst,
  input logic        xirq_req,
  input logic [15:0] bus_addr,
  input logic        bus_rd,
  input logic        bus_wr,
  input logic        op_fetch,
  input logic [7:0]  acc_first,
  input logic [7:0]  acc_second,
  input logic [15:0] idx_primary,
  input logic [15:0] stack_pointer,
  input logic [15:0] program_counter,
  input logic [7:0]  condition_flags_register
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_one_access; !(bus_rd && bus_wr); endproperty
  a_one_access: assert property (p_one_access) else $error("read with write");
  property p_vector; $past(rst) |-> bus_rd ##1 bus_rd && bus_addr == 16'hffff; endproperty
  a_vector: assert property (p_vector) else $error("vector fetch");
  property p_reset_regs;
    $past(rst) |-> stack_pointer == 16'h0 && condition_flags_register == 8'hd0;
  endproperty
  a_reset_regs: assert property (p_reset_regs) else $error("reset values");
  property p_fetch; op_fetch |-> bus_rd || $past(bus_rd); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch without read");
  property p_pc_step; op_fetch |-> program_counter == $past(bus_addr) + 16'h1; endproperty
  a_pc_step: assert property (p_pc_step) else $error("counter off fetch address");
  property p_x_sticky;
    !xirq_req && !$past(condition_flags_register[6]) |-> !condition_flags_register[6];
  endproperty
  a_x_sticky: assert property (p_x_sticky) else $error("mask set by transfer");
  property p_swap;
    idx_primary != $past(idx_primary) && idx_primary == {$past(acc_first), $past(acc_second)}
      |-> {acc_first, acc_second} == $past(idx_primary);
  endproperty
  a_swap: assert property (p_swap) else $error("swap lost index");
  property p_sp_down;
    stack_pointer == $past(stack_pointer) - 16'h1 |-> bus_wr || $past(bus_wr);
  endproperty
  a_sp_down: assert property (p_sp_down) else $error("stack drop without write");
  property p_sp_up;
    stack_pointer == $past(stack_pointer) + 16'h1
      |-> ##[0:2] bus_rd && bus_addr == stack_pointer;
  endproperty
  a_sp_up: assert property (p_sp_up) else $error("pull read missing");
  c_fetch: cover property (op_fetch);
  c_stacking: cover property (bus_wr ##1 bus_wr);
  c_pull: cover property (stack_pointer == $past(stack_pointer) + 16'h1);
endmodule
bind caid_core caid_core_sva i_sva (
  .clock(clock), .rst(rst), .xirq_req(xirq_req), .bus_addr(bus_addr), .bus_rd(bus_rd),
  .bus_wr(bus_wr), .op_fetch(op_fetch), .acc_first(acc_first), .acc_second(acc_second),
  .idx_primary(idx_primary), .stack_pointer(stack_pointer), .program_counter(program_counter),
  .condition_flags_register(condition_flags_register)
);

/* verif/caid_core_tb.sv */
// Self-checking bench for the datapath core
`timescale 1ns/1ns
module caid_core_tb;
  reg          clock;
  reg          rst;
  reg          irq_req;
  reg          xirq_req;
  wire [7:0]   bus_rdata;
  wire [7:0]   bus_wdata;
  wire [15:0]  bus_addr;
  wire         bus_rd;
  wire         bus_wr;
  wire         op_fetch;
  wire [7:0]   acc_first;
  wire [7:0]   acc_second;
  wire [15:0]  idx_primary;
  wire [15:0]  idx_secondary;
  wire [15:0]  stack_pointer;
  wire [7:0]   condition_flags_register;
  integer      fails = 0;
  integer      n_tests = 0;
  integer      cyc;
  integer      k;
  integer      t;
  integer      x;
  integer      y;
  logic [7:0]  a, b, c, m;
  logic [15:0] d, e;
  caid_core i_dut (
    .clock(clock), .rst(rst), .bus_rdata(bus_rdata), .irq_req(irq_req), .xirq_req(xirq_req),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .op_fetch(op_fetch), .acc_first(acc_first), .acc_second(acc_second),
    .idx_primary(idx_primary), .idx_secondary(idx_secondary), .stack_pointer(stack_pointer),
    .program_counter(), .condition_flags_register(condition_flags_register)
  );
  caid_mem i_mem (
    .clock(clock), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_rdata(bus_rdata)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] bcd(input integer v);
    bcd = {4'(v / 10), 4'(v % 10)};
  endfunction
  // Reset vector is 0101 from the fill; program loads there, run ends at read of stop
  task automatic run(input logic [7:0] p[$], input logic [15:0] stop = 16'h0);
    integer i;
    @(posedge clock);
    rst <= 1'b1;
    for (i = 0; i < 48; i++) i_mem.mem[16'h0101 + i] = i < p.size() ? p[i] : 8'h01;
    if (stop == 16'h0) stop = 16'h0101 + 16'(p.size());
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    cyc = 0;
    @(negedge clock);
    while (!(bus_rd && bus_addr == stop) && cyc < 300) begin
      @(negedge clock);
      cyc++;
    end
    chk(16'(cyc < 300), 16'h1);
    repeat (24) @(posedge clock);
  endtask
  initial begin
    {rst, irq_req, xirq_req} = 3'b100;
    a = $urandom(32'hb144);
    @(posedge clock);
    i_mem.mem[16'hfff2] = 8'h02;
    i_mem.mem[16'hfff3] = 8'h00;
    i_mem.mem[16'hfff4] = 8'h03;
    i_mem.mem[16'hfff5] = 8'h00;
    for (k = 0; k < 4; k++) begin
      a = k ? $urandom : 8'hff;
      b = k ? $urandom : 8'h01;
      c = $urandom;
      m = $urandom;
      e = k ? $urandom : 16'h0;
      x = $urandom % 100;
      y = k ? $urandom % 100 : 99;
      run('{8'h86, a, 8'hc6, b, 8'h1b});
      chk(acc_first, 8'(a + b));
      chk(acc_second, b);
      run('{8'h86, a, 8'hc6, b, 8'h10, 8'h11});
      chk(acc_first, 8'(a - b));
      chk(condition_flags_register[0], 8'(a - b) < b);
      run('{8'h86, a, 8'hc6, b, 8'h8f, 8'hc6, c, 8'h3a, 8'h08, 8'h08, 8'h09});
      chk(idx_primary, {a, b} + c + 16'h1);
      chk(acc_first, 8'h0);
      run('{8'h86, a, 8'hc6, b, 8'h18, 8'h8f, 8'hc6, c, 8'h18, 8'h3a, 8'h18, 8'h08});
      chk(idx_secondary, {a, b} + c + 16'h1);
      chk(idx_primary, 16'h0);
      d = 16'h2000 + e[12:0];
      run('{8'hce, d[15:8], d[7:0], 8'h86, a, 8'ha7, c, 8'h1c, c, m, 8'h1d, c, b, 8'ha6, c});
      d = d + c;
      chk(i_mem.mem[d], (a | m) & ~b);
      chk(acc_first, (a | m) & ~b);
      run('{8'hb6, d[15:8], d[7:0]});
      chk(acc_first, (a | m) & ~b);
      run('{8'h08});
      t = cyc;
      run('{8'h18, 8'h08});
      chk(16'(cyc), 16'(t + 1));
      run('{8'h86, bcd(x), 8'hc6, bcd(y), 8'h1b, 8'h19});
      chk(acc_first, bcd((x + y) % 100));
      chk(condition_flags_register[0], x + y > 99);
      chk(acc_second, bcd(y));
      run('{8'h86, a, 8'h06, 8'h86, b, 8'h06, 8'h07});
      chk(acc_first, {b[7], a[6] & b[6], b[5:0]});
      chk(condition_flags_register, {b[7], a[6] & b[6], b[5:0]});
      run('{8'hce, e[15:8], e[7:0], 8'h86, a, 8'hc6, b, 8'h02});
      chk(idx_primary, e ? {a, b} / e : 16'hffff);
      chk({acc_first, acc_second}, e ? {a, b} % e : {a, b});
      run('{8'hce, e[15:8] | 8'h80, e[7:0], 8'h86, a & 8'h7f, 8'hc6, b, 8'h03});
      chk(idx_primary, 16'({a & 8'h7f, b, 16'h0} / (e | 16'h8000)));
      run('{8'h8e, 8'h30, 8'h00, 8'h86, a, 8'h36, 8'h86, c, 8'h32});
      chk(i_mem.mem[16'h3000], a);
      chk(stack_pointer, 16'h3000);
      chk(acc_first, a);
      {xirq_req, irq_req} <= {k[0], 1'b1};
      run('{8'h8e, 8'h30, 8'h00, 8'hc6, b, 8'h86, 8'h00, 8'h06}, k[0] ? 16'h0300 : 16'h0200);
      {xirq_req, irq_req} <= 2'b00;
      chk(condition_flags_register, {1'b0, k[0], 6'h10});
      chk(i_mem.mem[16'h3000], 8'h0a);
      chk(i_mem.mem[16'h2ff9], b);
      chk(i_mem.mem[16'h2ff8], 8'h00);
      chk(stack_pointer, 16'h2ff7);
    end
    finish_test;
  end
  initial begin
    #100000;
    fails++;
    finish_test;
  end
endmodule
